/* rtl/tfs_defs.svh */
`ifndef TFS_DEFS_SVH
`define TFS_DEFS_SVH
// delay counter terminal counts, in speed clock ticks
`define TFS_PRE_SHORT 16'h0040
`define TFS_PRE_LONG 16'h0100
`define TFS_POST 16'h0020
`define TFS_HALT 16'h0030
`define TFS_IRG 16'h0010
// file mark codes: octal 23 and octal 17
`define TFS_FM_NORMAL 6'h13
`define TFS_FM_CORE 6'h0F
`define TFS_LRC_GAP 4'h4
`endif

/* rtl/tfs_pkg.sv */
package tfs_pkg;
	typedef enum logic [2:0] {
		ST_REST, ST_PRE1, ST_PRE2, ST_XFER,
		ST_POST, ST_HALTF, ST_HALTR, ST_WAIT
	} tfs_state_type;
endpackage

/* rtl/tfs_seq.sv */
`timescale 1ns/1ns
`include "tfs_defs.svh"
module tfs_seq
	import tfs_pkg::*;
#(
	parameter int CNT_W = 16
)(
	input wire logic i_sys_clk, // 20 MHz
	input wire logic i_rst, // sync, active high
	input wire logic i_command_strobe, // pin, load command
	input wire logic i_backward_dir_cmd, // reverse
	input wire logic i_write_cmd, // write record
	input wire logic i_file_mark_write_cmd, // write file mark
	input wire logic i_gap_cmd, // erase 3 inch gap
	input wire logic i_forward_space_cmd, // space
	input wire logic i_read_cmd, // read
	input wire logic i_clear_cmd, // clear
	input wire logic i_tape_return_cmd, // rewind
	input wire logic i_offline_cmd, // offline
	input wire logic i_odd_parity_select, // mode line
	input wire logic i_packing_high_select, // mode line
	input wire logic i_high_read_threshold, // mode line
	input wire logic i_low_read_threshold, // mode line
	input wire logic i_core_dump_fm_select, // mode line
	input wire logic i_nine_track, // selected unit is 9 track
	input wire logic i_manual_mode, // front panel override
	input wire logic i_dual_gap, // read-after-write unit
	input wire logic i_thr_fitted, // unit has threshold option
	input wire logic i_rewind_irq_en, // rewind sets busy
	input wire logic i_tape_start_mark, // at load point
	input wire logic i_rewinding, // unit rewinding
	input wire logic i_speed_tick, // speed clock pulse
	input wire logic i_read_strobe, // read data strobe
	input wire logic i_adaptor_halt, // halt from adaptor
	input wire logic i_mark_done, // file mark and lrc written
	input wire logic i_write_done, // write tail written
	output logic o_command_busy, // busy
	output logic o_data_busy, // data busy
	output logic o_forward_motion_cmd, // forward motion
	output logic o_reverse_motion_cmd, // reverse motion
	output logic o_rewind_pulse, // rewind to unit
	output logic o_offline_pulse, // offline to unit
	output logic o_cmd_reject, // strobe refused
	output logic o_odd_parity, // parity in use
	output logic o_high_density, // density in use
	output logic o_thr_high_act, // high threshold active
	output logic o_thr_low_act, // low threshold active
	output logic [5:0] o_fm_code, // file mark character
	output logic o_fm_even, // file mark even parity
	output logic o_data_xfer_en, // data exchange enabled
	output logic [2:0] o_state // sequencer state
);
	tfs_state_type state, next_state;
	logic [2:0] sync_stb, sync_rs, sync_tk, sync_rw;
	logic stb_edge, rs_edge, tick;
	logic [CNT_W-1:0] cnt;
	logic c_rev, c_wr, c_fm, c_gap, c_sp, c_rd, c_rwb;
	logic busy, rew_pend, offl_pend;

	// pins pass two flops; the third stage only feeds edge detect
	always_ff @(posedge i_sys_clk)
	begin
		sync_stb <= {sync_stb[1:0], i_command_strobe};
		sync_rs <= {sync_rs[1:0], i_read_strobe};
		sync_tk <= {sync_tk[1:0], i_speed_tick};
		sync_rw <= {sync_rw[1:0], i_rewinding};
	end
	assign stb_edge = sync_stb[1] & ~sync_stb[2];

	// command bits and adaptor/panel levels also cross two flops; the
	// command bits then line up with the strobe edge detect
	logic [8:0] cmd_s1, cmd_s2;
	logic [11:0] lvl_s1, lvl_s2;
	always_ff @(posedge i_sys_clk)
	begin
		cmd_s1 <= {i_backward_dir_cmd, i_write_cmd, i_file_mark_write_cmd,
			i_gap_cmd, i_forward_space_cmd, i_read_cmd, i_clear_cmd,
			i_tape_return_cmd, i_offline_cmd};
		cmd_s2 <= cmd_s1;
		lvl_s1 <= {i_odd_parity_select, i_packing_high_select,
			i_high_read_threshold, i_low_read_threshold,
			i_core_dump_fm_select, i_nine_track, i_manual_mode, i_dual_gap,
			i_thr_fitted, i_rewind_irq_en, i_tape_start_mark,
			i_adaptor_halt};
		lvl_s2 <= lvl_s1;
	end
	wire odd_sel = lvl_s2[11];
	wire dens_sel = lvl_s2[10];
	wire thr_hi_sel = lvl_s2[9];
	wire thr_lo_sel = lvl_s2[8];
	wire cd_sel = lvl_s2[7];
	wire nine_trk = lvl_s2[6];
	wire manual = lvl_s2[5];
	wire dual_gap = lvl_s2[4];
	wire thr_fit = lvl_s2[3];
	wire rew_irq = lvl_s2[2];
	wire at_start = lvl_s2[1];
	wire halt_req = lvl_s2[0];
	assign rs_edge = sync_rs[1] & ~sync_rs[2];
	assign tick = sync_tk[1] & ~sync_tk[2];

	// command decode; only the listed combinations are valid
	wire n_wr = cmd_s2[7];
	wire n_fm = cmd_s2[6];
	wire n_gap = cmd_s2[5];
	wire n_rd = cmd_s2[3];
	wire n_sp = cmd_s2[4];
	wire n_rv = cmd_s2[8];
	wire n_clr = cmd_s2[2];
	wire n_rew = cmd_s2[1];
	wire n_ofl = cmd_s2[0];
	wire any_motion = n_wr | n_fm | n_gap | n_rd | n_sp;
	wire any_sys = n_clr | n_rew | n_ofl;
	wire v_read = n_rd & ~(n_wr | n_fm | n_gap | n_sp | any_sys);
	wire v_space = (n_sp ^ n_rv) & ~(n_wr | n_fm | n_gap | n_rd | any_sys);
	wire v_writey = ~n_rv & ~n_rd & ~n_sp & ~any_sys
		& (n_wr | n_fm | n_gap) & ~(n_wr & n_fm);
	wire v_rew = n_rew & ~n_clr & ~any_motion & ~n_rv;
	wire v_ofl = n_ofl & ~n_rew & ~n_clr & ~any_motion & ~n_rv;
	wire v_clr = n_clr & ~n_rew & ~n_ofl & ~any_motion & ~n_rv;
	wire v_motion = v_read | v_space | v_writey;
	wire in_halt = state == ST_HALTF || state == ST_HALTR;
	wire chain_ok = in_halt & (v_read | (v_writey & n_wr));
	wire rew_busy = v_rew & rew_irq & ~n_ofl;
	wire take_cmd = stb_edge & (v_clr
		| (~busy & (v_motion | v_rew | v_ofl)) | chain_ok);
	wire busy_cmd = v_clr | rew_busy | v_motion;

	// delay counter terminal count by state
	logic [CNT_W-1:0] tc;
	assign tc = (state == ST_PRE1) ? CNT_W'(`TFS_PRE_SHORT) :
		(state == ST_PRE2) ? CNT_W'(`TFS_PRE_LONG) :
		(state == ST_POST) ? CNT_W'(`TFS_POST) :
		(state == ST_XFER) ? CNT_W'(`TFS_IRG) :
		CNT_W'(`TFS_HALT);
	wire cnt_stop = cnt >= tc;
	wire writey = c_wr | c_fm | c_gap;
	wire xfer_done = (c_gap & ~c_wr & ~c_fm) ? 1'b1 :
		(writey & ~dual_gap) ? (c_fm ? i_mark_done : i_write_done)
		: cnt_stop;

	// next state
	always_comb
	begin
		next_state = state;
		case (state)
			ST_REST, ST_HALTF, ST_HALTR:
			begin
				if (take_cmd & busy_cmd & (v_clr | rew_busy))
					next_state = ST_WAIT;
				else if (take_cmd & v_motion)
					next_state = (at_start | n_gap) ?
						ST_PRE2 : ST_PRE1;
				else if (state != ST_REST & cnt_stop)
					next_state = ST_REST;
			end
			ST_PRE1, ST_PRE2:
				if (cnt_stop)
					next_state = ST_XFER;
			ST_XFER:
				if (xfer_done)
					next_state = ST_POST;
			ST_POST:
				if (cnt_stop)
					next_state = c_rev ? ST_HALTR : ST_HALTF;
			ST_WAIT:
				if (~sync_rw[1] & ~c_rwb)
					next_state = ST_REST;
			default:
				next_state = ST_REST;
		endcase
		if (take_cmd & v_clr)
			next_state = ST_WAIT;
	end

	// state register and delay counter; three-bit, rest at reset
	always_ff @(posedge i_sys_clk)
	begin
		if (i_rst)
			state <= ST_REST;
		else
			state <= next_state;
	end
	always_ff @(posedge i_sys_clk)
	begin
		if (i_rst || next_state != state || (state == ST_XFER && rs_edge))
			cnt <= '0;
		else if (tick && !cnt_stop)
			cnt <= cnt + 1'b1;
	end

	// command storage: adaptor may drop bits after strobe
	always_ff @(posedge i_sys_clk)
	begin
		if (i_rst)
		begin
			{c_rev, c_wr, c_fm, c_gap, c_sp, c_rd, c_rwb} <= '0;
		end
		else if (take_cmd)
		begin
			{c_rev, c_wr, c_fm, c_gap, c_sp, c_rd} <=
				{n_rv, n_wr, n_fm, n_gap, n_sp, n_rd};
			c_rwb <= rew_busy;
		end
		// a busy rewind waits until the unit reports rewinding; a unit
		// that never answers is left only by a clear
		else if (sync_rw[1])
			c_rwb <= 1'b0;
	end

	// busy flag; plain offline or rewind leaves it clear
	always_ff @(posedge i_sys_clk)
	begin
		if (i_rst)
			busy <= 1'b0;
		else if (take_cmd & busy_cmd)
			busy <= 1'b1;
		else if (next_state == ST_REST && state != ST_REST)
			busy <= 1'b0;
	end

	// unit pulses; offline follows the rewind when both asked
	always_ff @(posedge i_sys_clk)
	begin
		if (i_rst)
		begin
			rew_pend <= 1'b0;
			offl_pend <= 1'b0;
			o_rewind_pulse <= 1'b0;
			o_offline_pulse <= 1'b0;
			o_cmd_reject <= 1'b0;
		end
		else
		begin
			o_rewind_pulse <= take_cmd & n_rew;
			rew_pend <= take_cmd & n_rew & n_ofl;
			offl_pend <= rew_pend;
			o_offline_pulse <= (take_cmd & v_ofl) | offl_pend;
			o_cmd_reject <= stb_edge & ~take_cmd;
		end
	end

	// motion and data busy follow the state
	assign o_command_busy = busy;
	assign o_state = state;
	wire moving = state == ST_PRE1 || state == ST_PRE2
		|| state == ST_XFER || state == ST_POST;
	always_ff @(posedge i_sys_clk)
	begin
		if (i_rst)
		begin
			o_forward_motion_cmd <= 1'b0;
			o_reverse_motion_cmd <= 1'b0;
			o_data_busy <= 1'b0;
			o_data_xfer_en <= 1'b0;
		end
		else
		begin
			o_forward_motion_cmd <= moving & ~c_rev;
			o_reverse_motion_cmd <= moving & c_rev;
			o_data_busy <= state == ST_XFER || state == ST_POST;
			o_data_xfer_en <= state == ST_XFER & (c_rd | c_wr)
				& ~halt_req;
		end
	end

	// mode lines are used live; the adaptor holds them steady
	wire remote7 = ~nine_trk & ~manual;
	always_ff @(posedge i_sys_clk)
	begin
		if (i_rst)
		begin
			o_odd_parity <= 1'b1;
			o_high_density <= 1'b1;
			o_thr_high_act <= 1'b0;
			o_thr_low_act <= 1'b0;
			o_fm_code <= `TFS_FM_NORMAL;
			o_fm_even <= 1'b0;
		end
		else
		begin
			o_odd_parity <= remote7 ? odd_sel : 1'b1;
			o_high_density <= remote7 ? dens_sel
				: 1'b1;
			o_thr_high_act <= thr_hi_sel & thr_fit
				& ~dual_gap & ~c_rev & (c_rd | c_sp);
			o_thr_low_act <= thr_lo_sel & thr_fit;
			o_fm_even <= nine_trk & cd_sel;
			o_fm_code <= (nine_trk & cd_sel) ?
				`TFS_FM_CORE : `TFS_FM_NORMAL;
		end
	end
endmodule

/* bench/tfs_xport_model.sv */
`timescale 1ns/1ns
// transport stand-in: free speed clock, one record per move, rewind time
module tfs_xport_model (
	input wire logic i_sys_clk, // system clock
	input wire logic i_rst, // sync reset
	input wire logic i_fwd, // forward motion
	input wire logic i_rev, // reverse motion
	input wire logic i_rewind, // rewind pulse
	output logic o_tick, // speed clock
	output logic o_strobe, // read strobe
	output logic o_rewinding // unit rewinding
);
	logic [1:0] div;
	logic [10:0] run;
	logic [6:0] rwd;
	// run counts cycles of motion, rwd the rewind still to go
	always_ff @(posedge i_sys_clk)
	begin
		div <= i_rst ? 2'h0 : div + 2'h1;
		run <= (i_fwd | i_rev) ? run + 11'h1 : 11'h0;
		rwd <= i_rewind ? 7'h64 : (i_rst || rwd == 7'h0) ? 7'h0 : rwd - 7'h1;
	end
	assign o_tick = div[1];
	// record only after a long start, so short moves see an empty gap
	assign o_strobe = run >= 11'h410 && run < 11'h4d8 && run[2];
	assign o_rewinding = rwd != 7'h0;
endmodule

/* bench/tfs_seq_properties.sv */
`timescale 1ns/1ns
module tfs_seq_properties (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_nine_track,
	input wire logic i_manual_mode,
	input wire logic i_odd_parity_select,
	input wire logic i_packing_high_select,
	input wire logic i_core_dump_fm_select,
	input wire logic i_thr_fitted,
	input wire logic o_command_busy,
	input wire logic o_data_busy,
	input wire logic o_forward_motion_cmd,
	input wire logic o_reverse_motion_cmd,
	input wire logic o_offline_pulse,
	input wire logic o_odd_parity,
	input wire logic o_high_density,
	input wire logic o_thr_low_act,
	input wire logic [5:0] o_fm_code,
	input wire logic o_fm_even,
	input wire logic [2:0] o_state
);
	default clocking @(posedge i_sys_clk);
	endclocking
	default disable iff (i_rst);
	// motion and data busy follow the state one cycle late, command busy in the
	// same cycle; mode outputs lag their pins by two sync flops and one register
	busy_state_a: assert property (o_command_busy == (o_state != 3'h0))
		else $error("busy and state disagree");
	dbusy_state_a: assert property (o_data_busy ==
		($past(o_state) inside {3'h3, 3'h4})) else $error("data busy wrong");
	motion_state_a: assert property ((o_forward_motion_cmd |
		o_reverse_motion_cmd) == ($past(o_state) inside {[3'h1:3'h4]}))
		else $error("motion outside states 1 to 4");
	motion_excl_a: assert property (!(o_forward_motion_cmd &&
		o_reverse_motion_cmd)) else $error("both motions");
	offline_idle_a: assert property (o_offline_pulse |-> !o_command_busy)
		else $error("offline set busy");
	fm_code_a: assert property (($past(i_nine_track, 3) &&
		$past(i_core_dump_fm_select, 3)) ? (o_fm_code == 6'h0f && o_fm_even)
		: (o_fm_code == 6'h13 && !o_fm_even)) else $error("file mark code");
	mode_follow_a: assert property (!$past(i_nine_track, 3) &&
		!$past(i_manual_mode, 3) |->
		o_odd_parity == $past(i_odd_parity_select, 3) &&
		o_high_density == $past(i_packing_high_select, 3))
		else $error("mode lines not followed");
	thr_fitted_a: assert property (o_thr_low_act |->
		$past(i_thr_fitted, 3))
		else $error("threshold on unfitted unit");
endmodule
bind tfs_seq tfs_seq_properties chk_u (.*);

/* bench/tfs_seq_test.sv */
`timescale 1ns/1ns
module tfs_seq_test;
	logic i_sys_clk, i_rst, i_command_strobe, i_backward_dir_cmd, i_write_cmd;
	logic i_file_mark_write_cmd, i_gap_cmd, i_forward_space_cmd, i_read_cmd;
	logic i_clear_cmd, i_tape_return_cmd, i_offline_cmd, i_odd_parity_select;
	logic i_packing_high_select, i_high_read_threshold, i_low_read_threshold;
	logic i_core_dump_fm_select, i_nine_track, i_manual_mode, i_dual_gap;
	logic i_thr_fitted, i_rewind_irq_en, i_tape_start_mark, i_rewinding;
	logic i_speed_tick, i_read_strobe, i_adaptor_halt, i_mark_done;
	logic i_write_done, o_command_busy, o_data_busy, o_forward_motion_cmd;
	logic o_reverse_motion_cmd, o_rewind_pulse, o_offline_pulse, o_cmd_reject;
	logic o_odd_parity, o_high_density, o_thr_high_act, o_thr_low_act;
	logic o_fm_even, o_data_xfer_en;
	logic [5:0] o_fm_code;
	logic [2:0] o_state;
	logic [8:0] cmd = 9'h0;
	int n_errors = 0, tests_run = 0, cyc = 0, t_rew = 0, t_ofl = 0, n_rej = 0;
	assign {i_backward_dir_cmd, i_write_cmd, i_file_mark_write_cmd, i_gap_cmd,
		i_forward_space_cmd, i_read_cmd, i_clear_cmd, i_tape_return_cmd,
		i_offline_cmd} = cmd;
	tfs_seq dut_u (.*);
	tfs_xport_model xp_u (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
		.i_fwd(o_forward_motion_cmd), .i_rev(o_reverse_motion_cmd),
		.i_rewind(o_rewind_pulse), .o_tick(i_speed_tick),
		.o_strobe(i_read_strobe), .o_rewinding(i_rewinding));
	initial
	begin
		i_sys_clk = 0;
		forever #25 i_sys_clk = ~i_sys_clk;
	end
	// pulses last one cycle, so stamp them as they pass
	always @(posedge i_sys_clk)
	begin
		cyc <= cyc + 1;
		if (o_rewind_pulse === 1'b1) t_rew <= cyc;
		if (o_offline_pulse === 1'b1) t_ofl <= cyc;
		if (o_cmd_reject === 1'b1) n_rej <= n_rej + 1;
	end
	task chk(input string s, input logic [5:0] e, input logic [5:0] g);
		tests_run++;
		if (g !== e)
		begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", s, e, g);
		end
	endtask
	task step(input int n);
		repeat (n) @(posedge i_sys_clk);
		#5;
	endtask
	// bits are dropped with the strobe; the device holds its own copy
	task strobe(input logic [8:0] c);
		cmd = c;
		i_command_strobe = 1;
		step(4);
		i_command_strobe = 0;
		cmd = 9'h0;
		step(2);
	endtask
	task wait_st(input logic [2:0] s);
		int k;
		for (k = 0; k < 3000 && o_state !== s; k++) step(1);
		chk("state reached", s, o_state);
	endtask
	task complete_run;
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task t_direct;
		int c0;
		c0 = cyc;
		chk("rest state", 3'h0, o_state);
		strobe(9'h001);
		chk("offline sent", 1'b1, t_ofl > c0);
		strobe(9'h002);
		chk("rewind sent", 1'b1, t_rew > c0);
		chk("still rest", 3'h0, o_state);
		strobe(9'h003);
		chk("rewind then offline", 6'h2, t_ofl - t_rew);
		c0 = n_rej;
		strobe(9'h0c0);
		chk("invalid refused", 6'h1, n_rej - c0);
		$display("direct commands done");
	endtask
	task t_read;
		int n0;
		i_tape_start_mark = 1;
		{i_high_read_threshold, i_thr_fitted} = 2'h3;
		strobe(9'h008);
		chk("long predelay", 3'h2, o_state);
		i_tape_start_mark = 0;
		wait_st(3'h3);
		step(100);
		chk("record hold", 3'h3, o_state);
		chk("data busy", 1'b1, o_data_busy);
		chk("forward", 1'b1, o_forward_motion_cmd);
		chk("thr high read", 1'b1, o_thr_high_act);
		chk("data exchange", 1'b1, o_data_xfer_en);
		i_adaptor_halt = 1;
		step(4);
		chk("halt stops exchange", 1'b0, o_data_xfer_en);
		chk("halt keeps record", 3'h3, o_state);
		i_adaptor_halt = 0;
		wait_st(3'h5);
		strobe(9'h008);
		chk("chained", 3'h1, o_state);
		step(200);
		chk("short predelay", 3'h1, o_state);
		n0 = n_rej;
		strobe(9'h008);
		chk("busy refused", 6'h1, n_rej - n0);
		step(80);
		chk("predelay over", 3'h3, o_state);
		strobe(9'h004);
		wait_st(3'h0);
		{i_high_read_threshold, i_thr_fitted} = 2'h0;
		$display("read and chain done");
	endtask
	task t_wait;
		i_rewind_irq_en = 1;
		strobe(9'h002);
		chk("rewind wait", 3'h7, o_state);
		step(50);
		chk("still rewinding", 3'h7, o_state);
		wait_st(3'h0);
		i_rewind_irq_en = 0;
		strobe(9'h020);
		chk("gap predelay", 3'h2, o_state);
		wait_st(3'h3);
		step(2);
		chk("erase leaves", 3'h4, o_state);
		wait_st(3'h5);
		wait_st(3'h0);
		$display("rewind and gap done");
	endtask
	// single-record reverse space
	task t_reverse;
		{i_high_read_threshold, i_thr_fitted} = 2'h3;
		strobe(9'h100);
		chk("space reverse", 3'h1, o_state);
		chk("reverse motion", 1'b1, o_reverse_motion_cmd);
		chk("no forward", 1'b0, o_forward_motion_cmd);
		chk("thr high reverse", 1'b0, o_thr_high_act);
		wait_st(3'h6);
		step(2);
		chk("motion stopped", 1'b0, o_reverse_motion_cmd);
		wait_st(3'h0);
		chk("idle busy", 1'b0, o_command_busy);
		{i_high_read_threshold, i_thr_fitted} = 2'h0;
		$display("reverse space done");
	endtask
	// mode lines move only while idle; they need two sync flops and a reg
	task t_modes;
		{i_odd_parity_select, i_packing_high_select} = 2'h0;
		step(4);
		chk("odd parity", 1'b0, o_odd_parity);
		chk("density", 1'b0, o_high_density);
		i_manual_mode = 1;
		step(4);
		chk("manual parity", 1'b1, o_odd_parity);
		chk("manual density", 1'b1, o_high_density);
		i_manual_mode = 0;
		{i_nine_track, i_core_dump_fm_select, i_low_read_threshold} = 3'h7;
		step(4);
		chk("parity ignored", 1'b1, o_odd_parity);
		chk("density ignored", 1'b1, o_high_density);
		chk("core mark", 6'h0f, o_fm_code);
		chk("core mark even", 1'b1, o_fm_even);
		chk("low thr unfitted", 1'b0, o_thr_low_act);
		i_thr_fitted = 1;
		step(4);
		chk("low thr fitted", 1'b1, o_thr_low_act);
		$display("mode lines done");
	endtask
	initial
	begin
		{i_command_strobe, i_high_read_threshold, i_low_read_threshold} = 3'h0;
		{i_core_dump_fm_select, i_nine_track, i_manual_mode, i_dual_gap} = 4'h0;
		{i_thr_fitted, i_rewind_irq_en, i_tape_start_mark} = 3'h0;
		{i_adaptor_halt, i_mark_done, i_write_done} = 3'h0;
		{i_rst, i_odd_parity_select, i_packing_high_select} = 3'h7;
		step(10);
		i_rst = 0;
		step(4);
		t_direct;
		t_read;
		t_wait;
		t_reverse;
		t_modes;
		complete_run;
	end
	initial
	begin
		repeat (20000) @(posedge i_sys_clk);
		n_errors++;
		complete_run;
	end
endmodule
